// *** design/sat_pkg.sv ***
/*
 * Shared constants and types for the store/arm/trigger control sequencer.
 * Assumes a single 10 MHz core clock and a synchronous, active-low reset.
 */
package sat_pkg;
  localparam int unsigned clk_period_ns = 100;
  localparam int unsigned sync_stages   = 2;
  localparam int unsigned holdoff_sweeps = 2;
  localparam logic        armed_rst     = 1'b0;
  localparam logic        sr_rst        = 1'b0;
  localparam logic        parity_rst    = 1'b0;
  localparam logic        two_sweep_rst = 1'b0;
  localparam logic        roll_ho_rst   = 1'b1;
  localparam logic        roll_prime_rst = 1'b1;
  localparam logic [1:0]  tp_zero       = 2'h0;

  typedef enum logic [1:0] {
    sat_mode_normal,
    sat_mode_refresh,
    sat_mode_roll
  } sat_mode_t;
endpackage : sat_pkg

// *** design/sat_btn_if.sv ***
/*
 * Carries one conditioned button between the conditioner and the sequencer.
 * Assumes both ends run on the core clock.
 */
`timescale 1ns/1ps
interface sat_btn_if;
  logic press;
  modport src (output press);
  modport dst (input press);
endinterface : sat_btn_if

// *** design/sat_btn_cond.sv ***
/*
 * Two-flop synchroniser and rising-edge detector for a debounced button.
 * Assumes the button is already debounced; gives one pulse per press.
 */
`timescale 1ns/1ps
module sat_btn_cond (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic btn_in,
  sat_btn_if.src    btn
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  logic press_reg;

  // Only sync_reg looks at meta_reg; the edge detect reads the second stage
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      meta_reg  <= 1'b0;
      sync_reg  <= 1'b0;
      last_reg  <= 1'b0;
      press_reg <= 1'b0;
    end else begin
      meta_reg  <= btn_in;
      sync_reg  <= meta_reg;
      last_reg  <= sync_reg;
      press_reg <= sync_reg & ~last_reg;
    end
  end

  assign btn.press = press_reg;
endmodule : sat_btn_cond

// *** design/sat_store_arm_trigger.sv ***
/*
 * Arm, trigger and stored sequencer for the acquisition store in refreshed
 * and roll display modes, with the two-sweep and roll hold-offs.
 * Assumes all status inputs except the buttons are on core_clk already.
 */
`timescale 1ns/1ps
module sat_store_arm_trigger (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       store_btn,
  input  wire logic       release_btn,
  input  wire logic       refresh_write_bs,
  input  wire logic       display_ramp_bs,
  input  wire logic       store_stop,
  input  wire logic       write_addr_lsb,
  input  wire logic       mode_roll,
  input  wire logic       mode_normal,
  input  wire logic       fast_refresh_range_line,
  input  wire logic       dual_trace,
  input  wire logic [1:0] trigger_point_switch,
  output logic            trigger_enable_line,
  output logic            armed_indicator,
  output logic            triggered_indicator,
  output logic            stored_indicator,
  output logic            refreshed_mode_indicator,
  output logic            store_write_enable,
  output logic            read_addr_lsb,
  output logic            sweep_inhibit,
  output logic [1:0]      trigger_point_offset
);
  sat_btn_if store_if ();
  sat_btn_if release_if ();

  sat_btn_cond u_store_cond (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .btn_in   (store_btn),
    .btn      (store_if.src)
  );

  sat_btn_cond u_release_cond (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .btn_in   (release_btn),
    .btn      (release_if.src)
  );

  // The sweep counter is two bits wide, so no more than four sweeps can be
  // held off; a larger count would wrap and release the trigger too early
  if (sat_pkg::holdoff_sweeps < 1 || sat_pkg::holdoff_sweeps > 4) begin : g_bad_holdoff
    $error("holdoff_sweeps out of range");
  end

  // Status lines from the timebase and store are on core_clk already
  logic refresh_last_reg;
  logic ramp_last_reg;
  logic wlsb_last_reg;
  logic stop_last_reg;

  logic armed_flop_reg;
  logic armed_flop_next;
  logic store_release_flop_reg;
  logic store_release_flop_next;
  logic sweep_parity_flop_reg;
  logic two_sweep_holdoff_flop_reg;
  logic roll_holdoff_flop_reg;
  logic roll_holdoff_prime_flop_reg;
  logic [1:0] sweep_cnt_reg;

  wire store_press   = store_if.press;
  wire release_press = release_if.press;
  wire trig_rise     = refresh_write_bs & ~refresh_last_reg;
  wire write_end     = ~refresh_write_bs & refresh_last_reg;
  wire sweep_end     = ~display_ramp_bs & ramp_last_reg;
  wire wlsb_toggle   = write_addr_lsb ^ wlsb_last_reg;
  wire stop_rise     = store_stop & ~stop_last_reg;
  // Both mode lines low means refreshed; normal mode is decoded only so that
  // the refreshed indicator and the two-sweep hold-off stay out of it
  wire refreshed     = ~mode_roll & ~mode_normal;
  wire fast_ho_en    = refreshed & fast_refresh_range_line;

  // Indicator decode follows the gate network: stored needs the flop set, the
  // write sequence finished and the armed flop clear
  wire stored_cond    = store_release_flop_reg & ~refresh_write_bs
                        & ~armed_flop_reg;
  wire triggered_cond = store_release_flop_reg & refresh_write_bs;

  // Arm/store term: after RELEASE the line is free outside roll, otherwise the
  // armed flop and the roll hold-off both have to agree
  wire arm_term   = (~store_release_flop_reg & ~mode_roll)
                    | (armed_flop_reg & roll_holdoff_flop_reg);
  wire ho_blocks  = fast_ho_en & two_sweep_holdoff_flop_reg;
  wire trig_en    = arm_term & ~ho_blocks;

  // Set wins over the trigger clear: a STORE in the same cycle as a trigger rearms
  always_comb begin
    // RELEASE is tested before STORE in one if/else, so it wins over a STORE in the same cycle
    armed_flop_next         = armed_flop_reg;
    store_release_flop_next = store_release_flop_reg;
    if (trig_rise) begin
      armed_flop_next = 1'b0;
    end
    if (release_press) begin
      armed_flop_next         = 1'b0;
      store_release_flop_next = 1'b0;
    end else if (store_press) begin
      armed_flop_next         = 1'b1;
      store_release_flop_next = 1'b1;
    end
  end

  // Trigger history: a rise is a new trigger, a fall ends the writing sequence
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      refresh_last_reg <= 1'b0;
    end else begin
      refresh_last_reg <= refresh_write_bs;
    end
  end

  // Ramp history: only the falling edge, the end of a sweep, is used
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ramp_last_reg <= 1'b0;
    end else begin
      ramp_last_reg <= display_ramp_bs;
    end
  end

  // Any change of the write address lsb counts, so both edges are kept
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wlsb_last_reg <= 1'b0;
    end else begin
      wlsb_last_reg <= write_addr_lsb;
    end
  end

  // STOP from the store is a short pulse; only its rise sets the hold-off
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      stop_last_reg <= 1'b0;
    end else begin
      stop_last_reg <= store_stop;
    end
  end

  // Armed: set by STORE, cleared by a trigger or by RELEASE
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      armed_flop_reg <= sat_pkg::armed_rst;
    end else begin
      armed_flop_reg <= armed_flop_next;
    end
  end

  // Set by STORE, cleared by RELEASE; marks that a result is being kept
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      store_release_flop_reg <= sat_pkg::sr_rst;
    end else begin
      store_release_flop_reg <= store_release_flop_next;
    end
  end

  // Parity toggles on every display sweep end
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sweep_parity_flop_reg <= sat_pkg::parity_rst;
    end else if (sweep_end) begin
      sweep_parity_flop_reg <= ~sweep_parity_flop_reg;
    end
  end

  // A write that is still running keeps the hold-off set, so a sweep cut short
  // by it can never count towards the two
  wire ho_set   = trig_rise | refresh_write_bs;
  wire ho_count = two_sweep_holdoff_flop_reg & sweep_end;
  wire ho_last  = (sweep_cnt_reg == 2'(sat_pkg::holdoff_sweeps - 1));

  // Hold-off counts finished sweeps only after the write ends; sweeps cut
  // short by the write are not counted, so a full read is guaranteed
  always_ff @(posedge core_clk) begin
    if (!reset_n || !fast_ho_en) begin
      two_sweep_holdoff_flop_reg <= sat_pkg::two_sweep_rst;
      sweep_cnt_reg              <= 2'h0;
    end else if (ho_set) begin
      two_sweep_holdoff_flop_reg <= 1'b1;
      sweep_cnt_reg              <= 2'h0;
    end else if (ho_count) begin
      if (ho_last) begin
        two_sweep_holdoff_flop_reg <= 1'b0;
        sweep_cnt_reg              <= 2'h0;
      end else begin
        sweep_cnt_reg <= sweep_cnt_reg + 2'h1;
      end
    end
  end

  // Roll hold-off: the prime flop stops an existing address match from
  // clearing the hold-off the moment STORE is pressed
  wire roll_clear = stored_cond;
  wire prime_set  = wlsb_toggle & ~roll_holdoff_prime_flop_reg;
  wire roll_set   = stop_rise & roll_holdoff_prime_flop_reg;

  // The stored condition holds both flops clear for as long as it lasts, like
  // a level clear input, so it wins over a STOP in the same cycle
  always_ff @(posedge core_clk) begin
    if (!reset_n || !mode_roll) begin
      roll_holdoff_prime_flop_reg <= sat_pkg::roll_prime_rst;
    end else if (roll_clear) begin
      roll_holdoff_prime_flop_reg <= 1'b0;
    end else if (prime_set) begin
      roll_holdoff_prime_flop_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n || !mode_roll) begin
      roll_holdoff_flop_reg <= sat_pkg::roll_ho_rst;
    end else if (roll_clear) begin
      roll_holdoff_flop_reg <= 1'b0;
    end else if (roll_set) begin
      roll_holdoff_flop_reg <= 1'b1;
    end
  end

  // Registered once more, so enable follows the state flops by one cycle
  wire       trigger_enable_next = trig_en;
  wire       armed_ind_next      = armed_flop_reg;
  wire       triggered_ind_next  = triggered_cond;
  wire       stored_ind_next     = stored_cond;
  wire       mode_ind_next       = refreshed & ~stored_cond;
  // Roll writes continuously except in the stored condition; refreshed
  // writing is paced by the write bistable, not by this line
  wire       write_enable_next   = ~(mode_roll & stored_cond);
  // Single trace reads every address, so the parity bit is masked off
  wire       read_lsb_next       = dual_trace & sweep_parity_flop_reg;
  wire       sweep_inhibit_next  = fast_ho_en & refresh_write_bs;
  wire [1:0] tp_offset_next      = refresh_write_bs ? trigger_point_switch
                                                    : sat_pkg::tp_zero;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      trigger_enable_line <= 1'b0;
    end else begin
      trigger_enable_line <= trigger_enable_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      armed_indicator <= 1'b0;
    end else begin
      armed_indicator <= armed_ind_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      triggered_indicator <= 1'b0;
    end else begin
      triggered_indicator <= triggered_ind_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      stored_indicator <= 1'b0;
    end else begin
      stored_indicator <= stored_ind_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      refreshed_mode_indicator <= 1'b0;
    end else begin
      refreshed_mode_indicator <= mode_ind_next;
    end
  end

  // Comes out of reset high, so the store is loaded from the start
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      store_write_enable <= 1'b1;
    end else begin
      store_write_enable <= write_enable_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      read_addr_lsb <= 1'b0;
    end else begin
      read_addr_lsb <= read_lsb_next;
    end
  end

  // A sweep already running ends by itself; only new sweeps are stopped
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sweep_inhibit <= 1'b0;
    end else begin
      sweep_inhibit <= sweep_inhibit_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      trigger_point_offset <= sat_pkg::tp_zero;
    end else begin
      trigger_point_offset <= tp_offset_next;
    end
  end
endmodule : sat_store_arm_trigger

// *** verification/sat_far_model.sv ***
/* Far side model: display ramp bistable and store write address lsb.
   Assumes core_clk and the block's sweep_inhibit and store_write_enable. */
`timescale 1ns/1ps
module sat_far_model (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic sweep_inhibit,
  input  wire logic store_write_enable,
  output logic      display_ramp_bs,
  output logic      write_addr_lsb
);
  logic [2:0] ramp_cnt_reg;
  wire        hold = sweep_inhibit && !display_ramp_bs;
  // Seven-cycle sweep, one cycle fly-back; a running sweep ends, no new one starts
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ramp_cnt_reg <= 3'h0;
      display_ramp_bs <= 1'b0;
      write_addr_lsb <= 1'b0;
    end else begin
      ramp_cnt_reg <= hold ? 3'h0 : ramp_cnt_reg + 3'h1;
      display_ramp_bs <= (ramp_cnt_reg != 3'h7) && !hold;
      if (store_write_enable) write_addr_lsb <= ~write_addr_lsb;
    end
  end
endmodule : sat_far_model

// *** verification/sat_store_arm_trigger_assertions.sv ***
/* Port checker for the store/arm/trigger sequencer.
   Assumes one core clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module sat_sat_checker (
  input wire logic       core_clk,
  input wire logic       reset_n,
  input wire logic       store_btn,
  input wire logic       release_btn,
  input wire logic       refresh_write_bs,
  input wire logic       mode_roll,
  input wire logic       mode_normal,
  input wire logic       fast_refresh_range_line,
  input wire logic       dual_trace,
  input wire logic [1:0] trigger_point_switch,
  input wire logic       trigger_enable_line,
  input wire logic       armed_indicator,
  input wire logic       triggered_indicator,
  input wire logic       stored_indicator,
  input wire logic       store_write_enable,
  input wire logic       read_addr_lsb,
  input wire logic       sweep_inhibit,
  input wire logic [1:0] trigger_point_offset
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_trig; $rose(refresh_write_bs); endsequence
  sequence s_fast_trig; s_trig ##0 (fast_refresh_range_line && !mode_roll && !mode_normal);
  endsequence
  property p_store_arms; $rose(store_btn) && !release_btn |-> ##[3:5] armed_indicator; endproperty
  property p_rel_clears; $rose(release_btn) |-> ##[3:5] !armed_indicator && !stored_indicator;
  endproperty
  property p_trig_disarms; s_trig |-> ##2 !armed_indicator; endproperty
  property p_write_end; !refresh_write_bs |=> !triggered_indicator; endproperty
  property p_stored_low; stored_indicator |-> !trigger_enable_line; endproperty
  property p_fast_hold; s_fast_trig |=> sweep_inhibit ##1 !trigger_enable_line; endproperty
  property p_roll_unarmed;
    mode_roll && $past(mode_roll) && !armed_indicator |-> !trigger_enable_line;
  endproperty
  property p_roll_nowrite; $rose(stored_indicator) && mode_roll |-> ##[0:1] !store_write_enable;
  endproperty
  property p_offset;
    trigger_point_offset == ($past(refresh_write_bs) ? $past(trigger_point_switch) : 2'h0);
  endproperty
  property p_dual; !dual_trace |=> !read_addr_lsb; endproperty
  a_store_arms: assert property (p_store_arms) else $error("no arm");
  a_rel_clears: assert property (p_rel_clears) else $error("no clear");
  a_trig_disarms: assert property (p_trig_disarms) else $error("still armed");
  a_write_end: assert property (p_write_end) else $error("triggered lit");
  a_stored_low: assert property (p_stored_low) else $error("enable in stored");
  a_fast_hold: assert property (p_fast_hold) else $error("no hold-off");
  a_roll_unarmed: assert property (p_roll_unarmed) else $error("roll enable");
  a_roll_nowrite: assert property (p_roll_nowrite) else $error("roll writes");
  a_offset: assert property (p_offset) else $error("bad offset");
  a_dual: assert property (p_dual) else $error("bad read lsb");
endmodule : sat_sat_checker
bind sat_store_arm_trigger sat_sat_checker i_sat_sat_checker (.*);

// *** verification/sat_store_arm_trigger_tb_top.sv ***
/* Self-checking bench for the store/arm/trigger sequencer.
   Assumes the far side model and the port checker bound to the block. */
`timescale 1ns/1ps
module sat_store_arm_trigger_tb_top;
  logic       core_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       store_btn = 1'b0, release_btn = 1'b0, refresh_write_bs = 1'b0;
  logic       store_stop = 1'b0, mode_roll = 1'b0, mode_normal = 1'b0;
  logic       fast_refresh_range_line = 1'b0, dual_trace = 1'b1;
  logic [1:0] trigger_point_switch = 2'h3;
  logic       display_ramp_bs, write_addr_lsb, trigger_enable_line, armed_indicator;
  logic       triggered_indicator, stored_indicator, refreshed_mode_indicator;
  logic       store_write_enable, read_addr_lsb, sweep_inhibit;
  logic [1:0] trigger_point_offset;
  int         n_errors = 0;
  int         cmp_count = 0;
  always #50 core_clk = ~core_clk;
  sat_store_arm_trigger i_sat_store_arm_trigger (.*);
  sat_far_model i_sat_far_model (.*);
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic chk(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask : chk
  // Button held five cycles, then low long enough to count as a new press
  task automatic press(input logic rel);
    @(posedge core_clk);
    if (rel) release_btn <= 1'b1; else store_btn <= 1'b1;
    cyc(4);
    @(posedge core_clk);
    release_btn <= 1'b0;
    store_btn <= 1'b0;
    cyc(5);
  endtask : press
  task automatic trig(input logic v);
    @(posedge core_clk);
    refresh_write_bs <= v;
    cyc(3);
  endtask : trig
  task automatic t_refresh();
    press(1);
    chk(trigger_enable_line, 1'b1, "rel en");
    chk(refreshed_mode_indicator, 1'b1, "rel mode led");
    press(0);
    chk(armed_indicator, 1'b1, "armed");
    chk(trigger_enable_line, 1'b1, "armed en");
    trig(1);
    chk(armed_indicator, 1'b0, "trig armed");
    chk(triggered_indicator, 1'b1, "trig lit");
    chk(stored_indicator, 1'b0, "trig stored");
    chk(trigger_point_offset == 2'h3, 1'b1, "offset pass");
    trig(0);
    chk(trigger_point_offset == 2'h0, 1'b1, "offset zero");
    chk(triggered_indicator, 1'b0, "end trig");
    chk(stored_indicator, 1'b1, "end stored");
    chk(refreshed_mode_indicator, 1'b0, "end mode led");
    chk(trigger_enable_line, 1'b0, "end en");
    press(0);
    chk(trigger_enable_line, 1'b1, "rearm en");
    trig(1);
    trig(0);
    press(1);
    chk(trigger_enable_line, 1'b1, "slow range en");
  endtask : t_refresh
  task automatic t_fast();
    int   falls;
    int   flips;
    logic prev;
    logic lsb;
    @(posedge core_clk);
    fast_refresh_range_line <= 1'b1;
    trig(1);
    chk(sweep_inhibit, 1'b1, "inhibit");
    chk(trigger_enable_line, 1'b0, "fast en");
    cyc(20);
    trig(0);
    falls = 0;
    flips = 0;
    for (int i = 0; i < 60 && !trigger_enable_line; i++) begin
      prev = display_ramp_bs;
      lsb  = read_addr_lsb;
      cyc(1);
      if (prev && !display_ramp_bs) falls++;
      if (lsb !== read_addr_lsb) flips++;
    end
    chk(falls == 2, 1'b1, "sweep count");
    chk(flips == 2, 1'b1, "read lsb flips");
    @(posedge core_clk);
    fast_refresh_range_line <= 1'b0;
    dual_trace <= 1'b0;
    cyc(20);
    chk(read_addr_lsb, 1'b0, "single read lsb");
    @(posedge core_clk);
    dual_trace <= 1'b1;
  endtask : t_fast
  task automatic t_roll();
    @(posedge core_clk);
    mode_roll <= 1'b1;
    press(1);
    chk(trigger_enable_line, 1'b0, "roll en");
    chk(store_write_enable, 1'b1, "roll write");
    trig(1);
    chk(triggered_indicator, 1'b0, "roll ignored");
    trig(0);
    press(0);
    chk(armed_indicator, 1'b1, "roll armed");
    chk(trigger_enable_line, 1'b1, "roll armed en");
    trig(1);
    chk(trigger_enable_line, 1'b0, "roll trig en");
    chk(triggered_indicator, 1'b1, "roll trig lit");
    trig(0);
    chk(stored_indicator, 1'b1, "roll stored");
    chk(store_write_enable, 1'b0, "roll stored write");
    press(0);
    chk(stored_indicator, 1'b0, "roll unstored");
    chk(store_write_enable, 1'b1, "roll rewrite");
    chk(trigger_enable_line, 1'b0, "roll held off");
    @(posedge core_clk);
    store_stop <= 1'b1;
    @(posedge core_clk);
    store_stop <= 1'b0;
    cyc(3);
    chk(trigger_enable_line, 1'b1, "stop en");
    press(1);
    @(posedge core_clk);
    mode_roll <= 1'b0;
    mode_normal <= 1'b1;
    cyc(3);
    chk(refreshed_mode_indicator, 1'b0, "normal mode led");
    @(posedge core_clk);
    mode_normal <= 1'b0;
  endtask : t_roll
  task automatic results();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  initial begin
    cyc(20);
    @(posedge core_clk);
    reset_n <= 1'b1;
    t_refresh();
    t_fast();
    t_roll();
    results();
  end
  // Whole run needs under 400 cycles
  initial begin
    repeat (3000) @(posedge core_clk);
    n_errors++;
    results();
  end
endmodule : sat_store_arm_trigger_tb_top
